// ### hw/xbmp_pkg.sv
// Constants for the external bus mastership port.
// Assumes one core clock; pins are synchronous to it.
//
// How it works
// - Granted master waits for busy line idle
// - Grant removed: release at cycle end
// - Async enable selects two-stage input synchronizers
// - Take bus after busy idle, hold busy
// - Parking keeps busy asserted after activity ends
// - Release busy: drive high, then let go
// - Drive column strobe while master and not in standby
// - Not master, enable clear: strobe floats
// - Bus clock toggles when master and trace
// - Bus clock leads core clock quarter period
// - Inverse bus clock driven only while master
// - Request asserted on need, dropped after
// - Reset drops request, returns to slave
package xbmp_pkg;
  // Operating mode bit positions
  localparam int unsigned XBMP_OMR_ASYNC_ARB_BIT = 13;
  localparam int unsigned XBMP_OMR_ATE_BIT = 6;
  localparam int unsigned XBMP_OMR_W = 16;
  // Clock phase counter: four phases per bus clock period
  localparam logic [1:0] XBMP_PH_RESET = 2'h0;
  localparam logic [1:0] XBMP_PH_BCLK_RISE = 2'h3;
  localparam logic [1:0] XBMP_PH_CORE_CLOCK_OUT_RISE = 2'h0;
  localparam logic [1:0] XBMP_PH_HALF = 2'h2;

  typedef enum logic [1:0] {
    XBMP_SLAVE   = 2'b00,
    XBMP_PENDING = 2'b01,
    XBMP_MASTER  = 2'b10,
    XBMP_RELEASE = 2'b11
  } xbmp_state_t;
endpackage

// ### hw/xbmp_port.sv
// Bus mastership port: arbitration, busy line, column strobe, bus clocks.
// Assumes pins are synchronous to clk_sys_i; the pad combines oe and out.
`timescale 1ns/10ps
`default_nettype none
module xbmp_port (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Core side
  input wire logic bus_need_i,
  input wire logic cycle_end_i,
  input wire logic standby_i,
  input wire logic [15:0] omr_i,
  input wire logic dram_mastership_enable_i,
  input wire logic col_strobe_n_i,
  output logic is_master_o,
  // Arbitration pins
  input wire logic bus_grant_in_n_i,
  output logic mastership_request_out_n_o,
  input wire logic shared_busy_line_n_i,
  output logic shared_busy_line_n_o,
  output logic shared_busy_line_oe_o,
  // Memory pins
  output logic col_strobe_n_o,
  output logic col_strobe_oe_o,
  output logic core_clock_out_o,
  output logic bus_clk_o,
  output logic bus_clk_oe_o,
  output logic bus_clk_n_o,
  output logic bus_clk_n_oe_o
);
  // ==========================================================
  // Input synchronizers
  logic grant_s1_q, grant_s2_q, busy_s1_q, busy_s2_q;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      grant_s1_q <= 1'b1;
      grant_s2_q <= 1'b1;
      busy_s1_q <= 1'b1;
      busy_s2_q <= 1'b1;
    end else begin
      grant_s1_q <= bus_grant_in_n_i;
      grant_s2_q <= grant_s1_q;
      busy_s1_q <= shared_busy_line_n_i;
      busy_s2_q <= busy_s1_q;
    end
  end

  wire async_arb = omr_i[xbmp_pkg::XBMP_OMR_ASYNC_ARB_BIT];
  wire trace_en = omr_i[xbmp_pkg::XBMP_OMR_ATE_BIT];
  // Standby masks inputs so a grant seen in stop/wait is not acted on
  wire grant_raw_n = async_arb ? grant_s2_q : bus_grant_in_n_i;
  wire busy_raw_n = async_arb ? busy_s2_q : shared_busy_line_n_i;
  wire granted = !grant_raw_n && !standby_i;
  wire busy_idle = busy_raw_n && !standby_i;

  // ==========================================================
  // Arbitration state machine
  xbmp_pkg::xbmp_state_t state_q, state_d;
  logic req_q;
  wire master = (state_q == xbmp_pkg::XBMP_MASTER);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      xbmp_pkg::XBMP_SLAVE: begin
        if (granted && req_q) begin
          state_d = xbmp_pkg::XBMP_PENDING;
        end
      end
      xbmp_pkg::XBMP_PENDING: begin
        if (!granted) begin
          state_d = xbmp_pkg::XBMP_SLAVE;
        end else if (busy_idle) begin
          state_d = xbmp_pkg::XBMP_MASTER;
        end
      end
      xbmp_pkg::XBMP_MASTER: begin
        // Parking: without new grant loss the bus stays ours
        if (!granted && cycle_end_i) begin
          state_d = xbmp_pkg::XBMP_RELEASE;
        end
      end
      xbmp_pkg::XBMP_RELEASE: begin
        state_d = xbmp_pkg::XBMP_SLAVE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= xbmp_pkg::XBMP_SLAVE;
      req_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= bus_need_i;
    end
  end

  // ==========================================================
  // Busy line: driven low while master, high one cycle on release
  assign shared_busy_line_n_o = !master;
  assign shared_busy_line_oe_o = master || (state_q == xbmp_pkg::XBMP_RELEASE);
  assign mastership_request_out_n_o = !req_q;
  assign is_master_o = master;

  // ==========================================================
  // Column strobe
  logic cas_q;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cas_q <= 1'b1;
    end else begin
      cas_q <= col_strobe_n_i;
    end
  end
  assign col_strobe_n_o = master ? cas_q : 1'b1;
  // Enable set keeps the strobe driven high when not master, outside standby
  assign col_strobe_oe_o = reset_n_i && !standby_i && (master || dram_mastership_enable_i);

  // ==========================================================
  // Clocks: four phases, bus clock rises one phase before core clock
  logic [1:0] phase_q;
  logic bclk_q, cko_q;
  wire [1:0] phase_nx = phase_q + 2'h1;
  wire cko_hi = (phase_nx - xbmp_pkg::XBMP_PH_CORE_CLOCK_OUT_RISE) < xbmp_pkg::XBMP_PH_HALF;
  wire bclk_hi = (phase_nx - xbmp_pkg::XBMP_PH_BCLK_RISE) < xbmp_pkg::XBMP_PH_HALF;
  wire bclk_run = master && trace_en;
  // Start only on the rise phase so the first bus clock pulse is never short
  wire bclk_start = bclk_q || (phase_nx == xbmp_pkg::XBMP_PH_BCLK_RISE);
  wire bclk_d = bclk_run && bclk_hi && bclk_start;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_q <= xbmp_pkg::XBMP_PH_RESET;
      bclk_q <= 1'b0;
      // Reset phase level, so no false core clock rise follows reset
      cko_q <= (xbmp_pkg::XBMP_PH_RESET - xbmp_pkg::XBMP_PH_CORE_CLOCK_OUT_RISE) < xbmp_pkg::XBMP_PH_HALF;
    end else begin
      phase_q <= phase_nx;
      cko_q <= cko_hi;
      bclk_q <= bclk_d;
    end
  end
  assign core_clock_out_o = cko_q;
  assign bus_clk_o = bclk_q;
  assign bus_clk_oe_o = master && !standby_i;
  assign bus_clk_n_o = !bclk_q;
  assign bus_clk_n_oe_o = master && !standby_i;

  // ==========================================================
  // Checks
  busy_wait_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(master) |-> $past(busy_idle))
    else $error("master taken while busy");

  busy_hold_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    master |-> shared_busy_line_oe_o && !shared_busy_line_n_o)
    else $error("busy not held");

  busy_rel_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $fell(master) |-> shared_busy_line_oe_o && shared_busy_line_n_o ##1 !shared_busy_line_oe_o)
    else $error("busy not actively released");

  grant_drop_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    master && !granted && cycle_end_i |=> !master)
    else $error("bus not released");

  sync_path_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    async_arb && $stable(async_arb) |-> grant_raw_n == $past(bus_grant_in_n_i, 2))
    else $error("grant not synchronized");

  cas_drive_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    master && !standby_i |-> col_strobe_oe_o)
    else $error("strobe not driven");

  cas_float_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !master && !dram_mastership_enable_i |-> !col_strobe_oe_o)
    else $error("strobe driven");

  bclk_idle_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !(master && trace_en) |=> !bclk_q)
    else $error("bus clock toggled");

  bclk_lead_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(bclk_q) |=> $rose(cko_q))
    else $error("bus clock lead wrong");

  req_track_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    mastership_request_out_n_o == !$past(bus_need_i))
    else $error("request wrong");

  slave_stay_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    state_q == xbmp_pkg::XBMP_SLAVE && !(granted && req_q) |=> state_q == xbmp_pkg::XBMP_SLAVE)
    else $error("slave left without grant");

  pend_entry_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    state_q == xbmp_pkg::XBMP_SLAVE && granted && req_q |=> state_q == xbmp_pkg::XBMP_PENDING)
    else $error("grant not taken as pending");

  pend_wait_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    state_q == xbmp_pkg::XBMP_PENDING && granted && !busy_idle |=> !master)
    else $error("pending left while busy");

  pend_take_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    state_q == xbmp_pkg::XBMP_PENDING && granted && busy_idle |=> master)
    else $error("idle bus not taken");

  pend_lost_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    state_q == xbmp_pkg::XBMP_PENDING && !granted |=> state_q == xbmp_pkg::XBMP_SLAVE)
    else $error("lost grant not dropped");

  take_path_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(master) |-> $past(state_q == xbmp_pkg::XBMP_PENDING))
    else $error("master taken without pending");

  park_hold_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    master && (granted || !cycle_end_i) |=> master)
    else $error("parked bus lost");

  park_req_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    master && mastership_request_out_n_o && !cycle_end_i |=> master && !shared_busy_line_n_o)
    else $error("parking ended without request");

  rel_entry_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $fell(master) |-> $past(!granted && cycle_end_i))
    else $error("release outside cycle end");

  rel_one_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    state_q == xbmp_pkg::XBMP_RELEASE |=> state_q == xbmp_pkg::XBMP_SLAVE)
    else $error("release longer than one cycle");

  rel_drive_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    state_q == xbmp_pkg::XBMP_RELEASE |-> shared_busy_line_oe_o && shared_busy_line_n_o)
    else $error("busy not driven high");

  slave_float_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !master && state_q != xbmp_pkg::XBMP_RELEASE |-> !shared_busy_line_oe_o)
    else $error("busy driven by slave");

  req_rise_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(bus_need_i) |=> !mastership_request_out_n_o)
    else $error("request not raised");

  req_fall_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $fell(bus_need_i) |=> mastership_request_out_n_o)
    else $error("request not dropped");

  sync_busy_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    async_arb && $stable(async_arb) |-> busy_raw_n == $past(shared_busy_line_n_i, 2))
    else $error("busy not synchronized");

  direct_grant_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !async_arb |-> grant_raw_n == bus_grant_in_n_i)
    else $error("grant not direct");

  direct_busy_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !async_arb |-> busy_raw_n == shared_busy_line_n_i)
    else $error("busy not direct");

  stby_mask_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    standby_i |-> !granted && !busy_idle)
    else $error("inputs not masked in standby");

  stby_pend_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    standby_i && state_q == xbmp_pkg::XBMP_PENDING |=> state_q == xbmp_pkg::XBMP_SLAVE)
    else $error("pending kept in standby");

  stby_slave_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    standby_i && state_q == xbmp_pkg::XBMP_SLAVE |=> state_q == xbmp_pkg::XBMP_SLAVE)
    else $error("grant acted on in standby");

  cas_stby_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    standby_i |-> !col_strobe_oe_o)
    else $error("strobe driven in standby");

  bclk_stby_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    standby_i |-> !bus_clk_oe_o && !bus_clk_n_oe_o)
    else $error("bus clocks driven in standby");

  cas_high_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !master |-> col_strobe_n_o)
    else $error("strobe active when not master");

  cas_follow_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    master |-> col_strobe_n_o == $past(col_strobe_n_i))
    else $error("strobe not passed through");

  bclkn_inv_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    bus_clk_n_oe_o |-> bus_clk_n_o == !bus_clk_o)
    else $error("inverse bus clock wrong");

  bclkn_float_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !master |-> !bus_clk_n_oe_o && !bus_clk_oe_o)
    else $error("bus clocks driven by slave");

  bclk_rise_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(bclk_q) |-> phase_q == xbmp_pkg::XBMP_PH_BCLK_RISE)
    else $error("bus clock rose off phase");

  cko_rise_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(cko_q) |-> phase_q == xbmp_pkg::XBMP_PH_CORE_CLOCK_OUT_RISE)
    else $error("core clock rose off phase");

  cko_width_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(cko_q) |=> cko_q ##1 !cko_q ##1 !cko_q ##1 cko_q)
    else $error("core clock period wrong");
endmodule
`default_nettype wire

// ### test/xbmp_arb_model.sv
// Far side: arbiter granting on request, another master, pull-up on busy.
// Assumes the bench opens the grant window and the other tenure.
`timescale 1ns/10ps
`default_nettype none
module xbmp_arb_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Bench control
  input wire logic allow_i,
  input wire logic other_busy_i,
  // Device pins
  input wire logic req_n_i,
  input wire logic busy_n_i,
  input wire logic busy_oe_i,
  output logic grant_n_o,
  output logic wire_n_o
);
  logic [1:0] gap_q;
  // Pull-up holds the wire when nobody drives
  assign wire_n_o = busy_oe_i ? busy_n_i : !other_busy_i;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      grant_n_o <= 1'b1;
      gap_q <= 2'h0;
    end else if (!grant_n_o) begin
      grant_n_o <= !allow_i;
      gap_q <= 2'h3;
    end else if (gap_q != 2'h0) begin
      gap_q <= gap_q - 2'h1;
    end else begin
      grant_n_o <= !(allow_i && !req_n_i);
    end
  end
endmodule
`default_nettype wire

// ### test/xbmp_port_bench.sv
// Bench: random strobe and enable, directed arbitration cases.
// Assumes the arbiter model and a 100 MHz core clock.
`timescale 1ns/10ps
`default_nettype none
module xbmp_port_bench;
  logic clk = 1'b0, rst_n = 1'b0, need = 1'b0, cend = 1'b0, stby = 1'b0;
  logic dme = 1'b0, cs_n = 1'b1, allow = 1'b0, other = 1'b0, prev, tog;
  logic [15:0] omr = 16'h0000;
  logic [7:0] lfsr = 8'h2f;
  logic is_m, req_n, bg_n, bb_n, bb_o, bb_oe, cs_o, cs_oe, cko, bc, bc_oe, bcn, bcn_oe;
  int fails = 0, n_checks = 0;
  xbmp_port xbmp_port_i (.clk_sys_i(clk), .reset_n_i(rst_n), .bus_need_i(need),
    .cycle_end_i(cend), .standby_i(stby), .omr_i(omr), .dram_mastership_enable_i(dme),
    .col_strobe_n_i(cs_n), .is_master_o(is_m), .bus_grant_in_n_i(bg_n),
    .mastership_request_out_n_o(req_n), .shared_busy_line_n_i(bb_n),
    .shared_busy_line_n_o(bb_o), .shared_busy_line_oe_o(bb_oe), .col_strobe_n_o(cs_o),
    .col_strobe_oe_o(cs_oe), .core_clock_out_o(cko), .bus_clk_o(bc), .bus_clk_oe_o(bc_oe),
    .bus_clk_n_o(bcn), .bus_clk_n_oe_o(bcn_oe));
  xbmp_arb_model xbmp_arb_model_i (.clk_sys_i(clk), .reset_n_i(rst_n), .allow_i(allow),
    .other_busy_i(other), .req_n_i(req_n), .busy_n_i(bb_o), .busy_oe_i(bb_oe),
    .grant_n_o(bg_n), .wire_n_o(bb_n));
  // ==========
  // Helpers
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic exp_cs_oe(input logic m, input logic en, input logic sb);
    return !sb && (m || en);
  endfunction
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Checks on settled values, then new random pins
  task automatic cyc(input int n);
    repeat (n) begin
      @(negedge clk);
      if (rst_n) begin
        chk("cs_oe", cs_oe, exp_cs_oe(is_m, dme, stby));
        chk("bcn_oe", bcn_oe, is_m && !stby);
        if (bcn_oe === 1'b1) chk("bcn", bcn, !bc);
        chk("cs", cs_o, is_m ? cs_n : 1'b1);
      end
      lfsr = lfsr_next(lfsr);
      cs_n = lfsr[0];
      dme = lfsr[1];
    end
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========
  // Clock, watchdog, sequence
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    fails++;
    end_sim();
  end
  initial begin
    cyc(8);
    chk("reset", {is_m, req_n, bb_oe, bc_oe}, 4'b0100);
    chk("reset_cs", cs_oe, 1'b0);
    rst_n = 1'b1;
    for (int m = 0; m < 2; m++) begin
      omr = {2'b00, m[0], 6'h00, 1'b1, 6'h00};
      other = 1'b1;
      need = 1'b1;
      allow = 1'b1;
      cyc(2);
      chk("req", req_n, 1'b0);
      cyc(10);
      chk("wait_busy", is_m, 1'b0);
      other = 1'b0;
      for (int i = 0; i < 12 && is_m !== 1'b1; i++) cyc(1);
      chk("take", {is_m, bb_oe, bb_o}, 3'b110);
      need = 1'b0;
      tog = 1'b0;
      repeat (8) begin
        prev = bc;
        cyc(1);
        tog = tog | (bc !== prev);
        if (bc !== prev) chk("lead", cko, prev);
      end
      chk("park", {is_m, req_n, bb_oe, bb_o}, 4'b1110);
      chk("bclk", {bc_oe, tog}, 2'b11);
      stby = 1'b1;
      allow = 1'b0;
      cyc(4);
      chk("standby", {is_m, bc_oe, cs_oe}, 3'b100);
      stby = 1'b0;
      cyc(6);
      chk("hold", {is_m, bb_oe}, 2'b11);
      cend = 1'b1;
      cyc(1);
      cend = 1'b0;
      chk("drive_high", {bb_oe, bb_o}, 2'b11);
      cyc(1);
      chk("let_go", {is_m, bb_oe, bc_oe}, 3'b000);
    end
    end_sim();
  end
endmodule
`default_nettype wire
